// ### design/tti_consts.svh
// Register offsets, field positions, reset values and fixed counts of the tick timer block
`ifndef TTI_CONSTS_SVH
`define TTI_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TTI_AW 12
`define TTI_OFS_CTRL 12'h010
`define TTI_OFS_RELOAD 12'h014
`define TTI_OFS_CURRENT 12'h018
`define TTI_OFS_CAL 12'h01c
`define TTI_OFS_EVT_STAT 12'h020
`define TTI_OFS_EVT_MASK 12'h024
`define TTI_OFS_SET_LO 12'h100
`define TTI_OFS_SET_HI 12'h104
`define TTI_OFS_CLR_LO 12'h180
`define TTI_OFS_CLR_HI 12'h184

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TTI_BIT_ENABLE 0
`define TTI_BIT_TICK_EXCEPTION_ENABLE 1
`define TTI_BIT_CLKSRC 2
`define TTI_BIT_COUNTFLAG 16
`define TTI_EVT_ZERO 0
`define TTI_EVT_PEND 1

// ----------------------------------------
// Widths, reset values and fixed counts
// ----------------------------------------
`define TTI_CNT_W 24
`define TTI_N_IRQ 50
`define TTI_N_IRQ_HI 18
`define TTI_N_EVT 2
`define TTI_CTRL_RESET 3'h0
`define TTI_EVT_MASK_RESET 2'h0
`define TTI_REF_DIVIDE 6'h20
`define TTI_REF_ABSENT 1'b0
`define TTI_CAL_INEXACT 1'b0
`define TTI_TEN_MS_COUNT 24'h00_09c4

`endif

// ### design/tti_pkg.sv
// Types of the tick timer and interrupt enable bank
`include "tti_consts.svh"

package tti_pkg;

  typedef logic [`TTI_AW-1:0] tti_addr_t;

  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_level;
    logic [4:0] div_cnt;
    logic ref_tick;
    logic enable;
    logic tick_exception_enable;
    logic clksrc;
    logic countflag;
    logic [`TTI_CNT_W-1:0] reload;
    logic [`TTI_CNT_W-1:0] current;
    logic [`TTI_N_IRQ-1:0] irq_en;
    logic [`TTI_N_EVT-1:0] evt_stat;
    logic [`TTI_N_EVT-1:0] evt_mask;
    logic [31:0] rdata;
    logic pend;
  } tti_state_s;

endpackage

// ### design/tti_top.sv
// Tick down-counter with reference divider, calibration word and interrupt enable bank
//
// Overview of operation
// - Select bit 0 counts reference, 1 CPU clock
// - Pend tick exception at zero only if enabled
// - Enable going high loads reload and starts
// - Reload is 24-bit read/write, upper bits zero
// - Reference tick is oscillator pin divided by 32
// - Current read gives live count, upper zero
// - Any current write forces count to zero
// - Current write also clears reached-zero flag
// - Calibration bit 31 shows reference clock absent
// - Calibration bit 30 shows inexact ten ms value
// - Calibration field gives fixed ten ms count
// - Fixed count assumes 8 MHz oscillator input
// - Set view writing one enables that interrupt
// - Set view reads current enable state
// - Clear view writing one disables that interrupt
// - Clear view reads same enable state
// - Interrupts 0-31 low word, 32-49 high word
// - Zero flag sets at zero, clears on read
`timescale 1ns/1ps
`default_nettype none
`include "tti_consts.svh"

module tti_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire tti_pkg::tti_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic oscillator_input_pin,
  output logic [`TTI_N_IRQ-1:0] irq_source_enable,
  output logic tick_exception_pend,
  output logic irq
);
  import tti_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  tti_state_s st;
  tti_state_s next_st;
  logic count_tick;
  logic zero_hit;
  logic wr_ctrl;
  logic wr_current;
  logic rd_ctrl;
  logic wr_enable_bank;

  assign wr_ctrl = reg_wr && (reg_addr == `TTI_OFS_CTRL);
  assign wr_current = reg_wr && (reg_addr == `TTI_OFS_CURRENT);
  assign rd_ctrl = reg_rd && (reg_addr == `TTI_OFS_CTRL);
  assign wr_enable_bank = reg_wr && ((reg_addr == `TTI_OFS_SET_LO) || (reg_addr == `TTI_OFS_SET_HI)
    || (reg_addr == `TTI_OFS_CLR_LO) || (reg_addr == `TTI_OFS_CLR_HI));
  assign count_tick = st.clksrc ? 1'b1 : st.ref_tick;
  assign zero_hit = st.enable && count_tick && (st.current == 24'h00_0001);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Pin is asynchronous; only a level seen twice alike is trusted
    next_st.osc_sync = {st.osc_sync[1:0], oscillator_input_pin};
    if (st.osc_sync[1] == st.osc_sync[2]) begin
      next_st.osc_level = st.osc_sync[2];
    end
    next_st.ref_tick = 1'b0;
    if (next_st.osc_level && !st.osc_level) begin
      if (st.div_cnt == 5'(`TTI_REF_DIVIDE - 6'h01)) begin
        next_st.div_cnt = 5'h00;
        next_st.ref_tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 5'h01;
      end
    end
    // Counting
    if (st.enable && count_tick) begin
      if (st.current == 24'h00_0000) begin
        next_st.current = st.reload;
      end else begin
        next_st.current = st.current - 24'h00_0001;
      end
    end
    // Clears first, sets after, so an event never gets lost
    if (rd_ctrl) begin
      next_st.countflag = 1'b0;
    end
    if (wr_ctrl) begin
      next_st.enable = reg_wdata[`TTI_BIT_ENABLE];
      next_st.tick_exception_enable = reg_wdata[`TTI_BIT_TICK_EXCEPTION_ENABLE];
      next_st.clksrc = reg_wdata[`TTI_BIT_CLKSRC];
      if (reg_wdata[`TTI_BIT_ENABLE] && !st.enable) begin
        next_st.current = st.reload;
      end
    end
    if (reg_wr && (reg_addr == `TTI_OFS_RELOAD)) begin
      next_st.reload = reg_wdata[`TTI_CNT_W-1:0];
    end
    if (wr_current) begin
      next_st.current = 24'h00_0000;
      next_st.countflag = 1'b0;
    end
    if (reg_wr && (reg_addr == `TTI_OFS_SET_LO)) begin
      next_st.irq_en[31:0] = st.irq_en[31:0] | reg_wdata;
    end
    if (reg_wr && (reg_addr == `TTI_OFS_SET_HI)) begin
      next_st.irq_en[49:32] = st.irq_en[49:32] | reg_wdata[`TTI_N_IRQ_HI-1:0];
    end
    if (reg_wr && (reg_addr == `TTI_OFS_CLR_LO)) begin
      next_st.irq_en[31:0] = st.irq_en[31:0] & ~reg_wdata;
    end
    if (reg_wr && (reg_addr == `TTI_OFS_CLR_HI)) begin
      next_st.irq_en[49:32] = st.irq_en[49:32] & ~reg_wdata[`TTI_N_IRQ_HI-1:0];
    end
    if (reg_wr && (reg_addr == `TTI_OFS_EVT_STAT)) begin
      next_st.evt_stat = st.evt_stat & ~reg_wdata[`TTI_N_EVT-1:0];
    end
    if (reg_wr && (reg_addr == `TTI_OFS_EVT_MASK)) begin
      next_st.evt_mask = reg_wdata[`TTI_N_EVT-1:0];
    end
    next_st.pend = zero_hit && st.tick_exception_enable;
    if (zero_hit) begin
      next_st.countflag = 1'b1;
      next_st.evt_stat[`TTI_EVT_ZERO] = 1'b1;
    end
    if (next_st.pend) begin
      next_st.evt_stat[`TTI_EVT_PEND] = 1'b1;
    end
    // Read data, valid only in the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `TTI_OFS_CTRL: begin
          next_st.rdata[`TTI_BIT_ENABLE] = st.enable;
          next_st.rdata[`TTI_BIT_TICK_EXCEPTION_ENABLE] = st.tick_exception_enable;
          next_st.rdata[`TTI_BIT_CLKSRC] = st.clksrc;
          next_st.rdata[`TTI_BIT_COUNTFLAG] = st.countflag;
        end
        `TTI_OFS_RELOAD: begin
          next_st.rdata = {8'h00, st.reload};
        end
        `TTI_OFS_CURRENT: begin
          next_st.rdata = {8'h00, st.current};
        end
        `TTI_OFS_CAL: begin
          // Exact only with an 8 MHz oscillator behind the divider
          next_st.rdata = {`TTI_REF_ABSENT, `TTI_CAL_INEXACT, 6'h00, `TTI_TEN_MS_COUNT};
        end
        `TTI_OFS_EVT_STAT: begin
          next_st.rdata = {30'h0000_0000, st.evt_stat};
        end
        `TTI_OFS_EVT_MASK: begin
          next_st.rdata = {30'h0000_0000, st.evt_mask};
        end
        `TTI_OFS_SET_LO, `TTI_OFS_CLR_LO: begin
          next_st.rdata = st.irq_en[31:0];
        end
        `TTI_OFS_SET_HI, `TTI_OFS_CLR_HI: begin
          next_st.rdata = {14'h0000, st.irq_en[49:32]};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = st.rdata;
  assign irq_source_enable = st.irq_en;
  assign tick_exception_pend = st.pend;
  assign irq = |(st.evt_stat & st.evt_mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync);

  sequence s_cur_write;
    wr_current && !zero_hit;
  endsequence

  sequence s_cleared;
    (st.current == 24'h00_0000) && !st.countflag;
  endsequence

  a_cpu_clock_count: assert property (
    (st.enable && st.clksrc && st.current > 24'h00_0001 && !wr_ctrl && !wr_current)
    |=> st.current == $past(st.current) - 24'h00_0001)
    else $error("count did not step on cpu clock");
  a_ref_clock_hold: assert property (
    (st.enable && !st.clksrc && !st.ref_tick && !wr_ctrl && !wr_current)
    |=> $stable(st.current))
    else $error("count moved without reference tick");
  a_pend_gated: assert property (
    tick_exception_pend |-> $past(st.tick_exception_enable) && st.countflag)
    else $error("pend without enable or flag");
  a_pend_taken: assert property (
    (zero_hit && st.tick_exception_enable) |=> tick_exception_pend ##1 !tick_exception_pend)
    else $error("pend missing or not a pulse");
  a_enable_load: assert property (
    (wr_ctrl && reg_wdata[0] && !st.enable) |=> st.enable && st.current == $past(st.reload))
    else $error("enable did not load reload");
  a_reload_read: assert property (
    (reg_rd && reg_addr == `TTI_OFS_RELOAD) |=> reg_rdata == {8'h00, $past(st.reload)})
    else $error("reload readback wrong");
  a_ref_divide: assert property (
    st.ref_tick |=> !st.ref_tick [*8])
    else $error("reference ticks too close");
  a_current_read: assert property (
    (reg_rd && reg_addr == `TTI_OFS_CURRENT) |=> reg_rdata == {8'h00, $past(st.current)})
    else $error("current readback wrong");
  a_current_clear: assert property (
    s_cur_write |=> s_cleared)
    else $error("current write did not clear");
  a_cal_word: assert property (
    (reg_rd && reg_addr == `TTI_OFS_CAL) |=> reg_rdata == 32'h0000_09c4)
    else $error("calibration word wrong");
  a_set_enable: assert property (
    (reg_wr && reg_addr == `TTI_OFS_SET_LO)
    |=> st.irq_en[31:0] == ($past(st.irq_en[31:0]) | $past(reg_wdata)))
    else $error("set view wrong");
  a_clr_enable: assert property (
    (reg_wr && reg_addr == `TTI_OFS_CLR_HI)
    |=> st.irq_en[49:32] == ($past(st.irq_en[49:32]) & ~$past(reg_wdata[17:0])))
    else $error("clear view wrong");
  a_enable_view: assert property (
    (reg_rd && (reg_addr == `TTI_OFS_SET_HI || reg_addr == `TTI_OFS_CLR_HI))
    |=> reg_rdata == {14'h0000, $past(st.irq_en[49:32])})
    else $error("enable view wrong");
  a_flag_read_clear: assert property (
    (rd_ctrl && !zero_hit) |=> !st.countflag)
    else $error("flag not cleared by read");
  a_flag_set: assert property (
    zero_hit |=> st.countflag && st.current == 24'h00_0000)
    else $error("flag not set at zero");
  a_wrap_reload: assert property (
    (st.enable && count_tick && st.current == 24'h00_0000 && !wr_ctrl && !wr_current)
    |=> st.current == $past(st.reload))
    else $error("no reload after zero");
  a_disabled_hold: assert property (
    (!st.enable && !wr_ctrl && !wr_current)
    |=> $stable(st.current))
    else $error("count moved while disabled");
  a_ctrl_write: assert property (
    wr_ctrl
    |=> {st.clksrc, st.tick_exception_enable, st.enable} == $past(reg_wdata[2:0]))
    else $error("control bits not stored");
  a_ctrl_read: assert property (
    rd_ctrl
    |=> reg_rdata == {15'h0000, $past(st.countflag), 13'h0000, $past(st.clksrc),
      $past(st.tick_exception_enable), $past(st.enable)})
    else $error("control readback wrong");
  a_pend_quiet: assert property (
    !st.tick_exception_enable
    |=> !tick_exception_pend)
    else $error("pend with exception disabled");
  a_pend_pulse: assert property (
    tick_exception_pend
    |=> !tick_exception_pend)
    else $error("pend longer than one cycle");
  a_reload_write: assert property (
    (reg_wr && reg_addr == `TTI_OFS_RELOAD)
    |=> st.reload == $past(reg_wdata[23:0]))
    else $error("reload not stored");
  a_reload_hold: assert property (
    !(reg_wr && reg_addr == `TTI_OFS_RELOAD)
    |=> $stable(st.reload))
    else $error("reload changed without write");
  a_flag_hold: assert property (
    (!zero_hit && !rd_ctrl && !wr_current)
    |=> $stable(st.countflag))
    else $error("flag changed without cause");

  // ----------------------------------------
  // Reference divider checks
  // ----------------------------------------
  // A level seen only once may be a metastable glitch
  a_sync_hold: assert property (
    (st.osc_sync[1] != st.osc_sync[2])
    |=> $stable(st.osc_level))
    else $error("pin level taken before it settled");
  a_sync_agree: assert property (
    (st.osc_sync[1] == st.osc_sync[2] && st.osc_sync[2] != st.osc_level)
    |=> st.osc_level == $past(st.osc_sync[2]))
    else $error("settled pin level not taken");
  a_div_step: assert property (
    !$stable(st.div_cnt)
    |-> $rose(st.osc_level))
    else $error("divider stepped without pin rise");
  a_div_tick: assert property (
    st.ref_tick
    |-> st.div_cnt == 5'h00)
    else $error("reference tick off the wrap");

  // ----------------------------------------
  // Enable bank and event checks
  // ----------------------------------------
  a_set_high: assert property (
    (reg_wr && reg_addr == `TTI_OFS_SET_HI)
    |=> st.irq_en[49:32] == ($past(st.irq_en[49:32]) | $past(reg_wdata[17:0])))
    else $error("high set view wrong");
  a_clr_low: assert property (
    (reg_wr && reg_addr == `TTI_OFS_CLR_LO)
    |=> st.irq_en[31:0] == ($past(st.irq_en[31:0]) & ~$past(reg_wdata)))
    else $error("low clear view wrong");
  a_enable_low_view: assert property (
    (reg_rd && (reg_addr == `TTI_OFS_SET_LO || reg_addr == `TTI_OFS_CLR_LO))
    |=> reg_rdata == $past(st.irq_en[31:0]))
    else $error("low enable view wrong");
  a_enable_hold: assert property (
    !wr_enable_bank
    |=> $stable(st.irq_en))
    else $error("enables changed without write");
  a_evt_zero_set: assert property (
    zero_hit
    |=> st.evt_stat[`TTI_EVT_ZERO])
    else $error("zero event not recorded");
  a_evt_pend_set: assert property (
    (zero_hit && st.tick_exception_enable)
    |=> st.evt_stat[`TTI_EVT_PEND])
    else $error("pend event not recorded");
  a_evt_clear: assert property (
    (reg_wr && reg_addr == `TTI_OFS_EVT_STAT && !zero_hit)
    |=> (st.evt_stat & $past(reg_wdata[1:0])) == 2'b00)
    else $error("event status not cleared");
  a_mask_write: assert property (
    (reg_wr && reg_addr == `TTI_OFS_EVT_MASK)
    |=> st.evt_mask == $past(reg_wdata[1:0]))
    else $error("event mask not stored");
  a_irq_raise: assert property (
    (tick_exception_pend && st.evt_mask[`TTI_EVT_PEND])
    |-> irq)
    else $error("unmasked pend gave no interrupt");
  a_irq_masked: assert property (
    (st.evt_mask == 2'b00)
    |-> !irq)
    else $error("interrupt with all events masked");
  a_evt_stat_read: assert property (
    (reg_rd && reg_addr == `TTI_OFS_EVT_STAT)
    |=> reg_rdata == {30'h0000_0000, $past(st.evt_stat)})
    else $error("event status readback wrong");
  a_evt_mask_read: assert property (
    (reg_rd && reg_addr == `TTI_OFS_EVT_MASK)
    |=> reg_rdata == {30'h0000_0000, $past(st.evt_mask)})
    else $error("event mask readback wrong");
  // Read data only in the cycle after a strobe, so stale words never leak
  a_rdata_idle: assert property (
    !reg_rd
    |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property (
    (reg_rd && reg_addr == 12'h000)
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ### test/tti_core_model.sv
// Processor core model: register bus master and oscillator source
`timescale 1ns/1ps
`default_nettype none

module tti_core_model (
  input wire logic clk_sys,
  output tti_pkg::tti_addr_t reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic oscillator_input_pin
);
  import tti_pkg::*;

  logic [2:0] osc_cnt;

  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    oscillator_input_pin = 1'b0;
    osc_cnt = '0;
  end

  // Free-running crystal, half period of 8 system cycles
  always @(posedge clk_sys) begin
    osc_cnt <= osc_cnt + 3'd1;
    if (&osc_cnt) begin
      oscillator_input_pin <= ~oscillator_input_pin;
    end
  end

  task automatic wr(input tti_addr_t a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Stale data is inverted so nothing leans on it
    reg_wdata <= ~d;
  endtask

  task automatic rd(input tti_addr_t a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tti_tb_top.sv
// Self-checking testbench of the tick timer and enable bank
`timescale 1ns/1ps
`default_nettype none
`include "tti_consts.svh"

module tti_tb_top;
  import tti_pkg::*;

  logic clk_sys;
  logic rst_b;
  tti_addr_t reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic oscillator_input_pin;
  logic [`TTI_N_IRQ-1:0] irq_source_enable;
  logic tick_exception_pend;
  logic irq;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  tti_top tti_top_inst (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .oscillator_input_pin(oscillator_input_pin),
    .irq_source_enable(irq_source_enable),
    .tick_exception_pend(tick_exception_pend),
    .irq(irq)
  );

  tti_core_model tti_core_model_inst (
    .clk_sys(clk_sys),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .oscillator_input_pin(oscillator_input_pin)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input tti_addr_t a, input logic [31:0] d);
    tti_core_model_inst.wr(a, d);
  endtask

  task automatic rd(input tti_addr_t a, input logic [31:0] e);
    exp_q.push_back(e);
    tti_core_model_inst.rd(a);
  endtask

  // Bounded wait; a miss leaves -1 and spoils the interval
  task automatic wait_pend(output int t);
    t = -1;
    for (int i = 0; i < 3000 && t < 0; i++) begin
      @(negedge clk_sys);
      if (tick_exception_pend === 1'b1) begin
        t = cyc;
      end
    end
  endtask

  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rd_seen <= reg_rd;
  end

  // Read data stands only in the cycle after the strobe
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #40000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int t0;
    int t1;
    int np;
    logic [31:0] r;
    logic [31:0] h;
    rst_b = 1'b0;
    void'($urandom(97));
    r = $urandom();
    h = $urandom();
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`TTI_OFS_CAL, 32'h0000_09c4);
    rd(`TTI_OFS_CTRL, 32'h0000_0000);
    rd(`TTI_OFS_SET_HI, 32'h0000_0000);
    rd(12'h300, 32'h0000_0000);
    wr(`TTI_OFS_CAL, 32'hffff_ffff);
    rd(`TTI_OFS_CAL, 32'h0000_09c4);
    wr(`TTI_OFS_SET_LO, r);
    wr(`TTI_OFS_SET_HI, h);
    wr(`TTI_OFS_SET_LO, 32'h0000_0000);
    rd(`TTI_OFS_SET_LO, r);
    rd(`TTI_OFS_CLR_HI, h & 32'h0003_ffff);
    wr(`TTI_OFS_CLR_LO, h);
    wr(`TTI_OFS_CLR_HI, r);
    rd(`TTI_OFS_CLR_LO, r & ~h);
    @(negedge clk_sys);
    chk(64'({h[17:0] & ~r[17:0], r & ~h}), 64'(irq_source_enable));
    wr(`TTI_OFS_RELOAD, 32'hffff_ffff);
    rd(`TTI_OFS_RELOAD, 32'h00ff_ffff);
    // CPU clock count: reload 5 gives a pend every 6 cycles
    wr(`TTI_OFS_RELOAD, 32'h0000_0005);
    wr(`TTI_OFS_CTRL, 32'h0000_0007);
    wait_pend(t0);
    wait_pend(t1);
    chk(64'(t1 - t0), 64'd6);
    wr(`TTI_OFS_CTRL, 32'h0000_0000);
    rd(`TTI_OFS_CTRL, 32'h0001_0000);
    rd(`TTI_OFS_CTRL, 32'h0000_0000);
    wr(`TTI_OFS_EVT_MASK, 32'h0000_0002);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(`TTI_OFS_EVT_STAT, 32'h0000_0002);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    rd(`TTI_OFS_EVT_STAT, 32'h0000_0001);
    // Exception enable off: counting but no pend
    wr(`TTI_OFS_CTRL, 32'h0000_0005);
    np = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (tick_exception_pend !== 1'b0) begin
        np++;
      end
    end
    chk(64'(np), 64'd0);
    wr(`TTI_OFS_CTRL, 32'h0000_0000);
    wr(`TTI_OFS_CURRENT, 32'ha5a5_a5a5);
    rd(`TTI_OFS_CURRENT, 32'h0000_0000);
    rd(`TTI_OFS_CTRL, 32'h0000_0000);
    // Reference count: 32 pin periods of 16 cycles per tick
    wr(`TTI_OFS_RELOAD, 32'h0000_0001);
    wr(`TTI_OFS_CTRL, 32'h0000_0003);
    wait_pend(t0);
    wait_pend(t1);
    chk(64'(t1 - t0), 64'd1024);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
